// ===== verilog/ustx_top.sv
// Serial transmitter with frame formatter, fractional baud generator and Avalon-MM registers
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ustx_consts.svh"
module ustx_top
   import ustx_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Serial pins
   output logic txd_o,
   output logic txd_oe,
   input wire logic txd_i,
   input wire logic xck_i,
   output logic line_driver_direction,
   // Receiver side tap
   output logic rx_line,
   input wire logic rx_done
);
   if (ADDR_W < 3) begin : g_addr_check
      $error("ADDR_W too small for register map");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [1:0] xck_sync_reg, xck_sync_next;
   logic [1:0] txi_sync_reg, txi_sync_next;
   logic xck_prev_reg, xck_prev_next;
   always_comb begin
      xck_sync_next = {xck_sync_reg[0], xck_i};
      txi_sync_next = {txi_sync_reg[0], txd_i};
      xck_prev_next = xck_sync_reg[1];
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         xck_sync_reg <= 2'h3;
         txi_sync_reg <= 2'h3;
         // Matches the synchroniser's reset level so no false edge follows reset
         xck_prev_reg <= 1'b1;
      end else begin
         xck_sync_reg <= xck_sync_next;
         txi_sync_reg <= txi_sync_next;
         xck_prev_reg <= xck_prev_next;
      end
   end
   // Only the second stage is read beyond this point
   logic xck_rise;
   assign xck_rise = xck_sync_reg[1] & ~xck_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [15:0] baud_reg, baud_next;
   logic [7:0] ctrla_reg, ctrla_next;
   logic [7:0] ctrlb_reg, ctrlb_next;
   logic [7:0] ctrlc_reg, ctrlc_next;
   logic [8:0] dreg_reg, dreg_next;
   logic dfull_reg, dfull_next;
   logic hpend_reg, hpend_next;
   logic [8:0] buf_reg, buf_next;
   logic bfull_reg, bfull_next;
   logic txc_reg, txc_next;
   logic rxc_reg, rxc_next;
   logic txon_reg, txon_next;
   logic shift_load, frame_end, shifter_busy;

   ustx_size_t size;
   ustx_par_t par;
   logic sync_mode, xclk_in;
   assign size = ustx_size_t'(ctrlc_reg[`USTX_CC_SIZE_LSB +: 3]);
   assign par = ustx_par_t'(ctrlc_reg[`USTX_CC_PAR_LSB +: 2]);
   assign sync_mode = ctrlc_reg[`USTX_CC_SYNC];
   assign xclk_in = ctrlc_reg[`USTX_CC_XCLKIN];

   logic is9l, is9h, wr, rd, dre;
   assign is9l = (size == USTX_SZ9L);
   assign is9h = (size == USTX_SZ9H);
   assign wr = avs_write;
   assign rd = avs_read;
   assign dre = ~dfull_reg & ~hpend_reg;
   // Single-cycle answer: no wait states
   assign avs_waitrequest = 1'b0;

   always_comb begin
      baud_next = baud_reg;
      ctrla_next = ctrla_reg;
      ctrlb_next = ctrlb_reg;
      ctrlc_next = ctrlc_reg;
      dreg_next = dreg_reg;
      dfull_next = dfull_reg;
      hpend_next = hpend_reg;
      buf_next = buf_reg;
      bfull_next = bfull_reg;
      txc_next = txc_reg;
      rxc_next = rxc_reg;
      txon_next = txon_reg;
      // Data register moves to buffer once buffer empties (or shifter takes it)
      if (shift_load) begin
         bfull_next = 1'b0;
      end
      if (dfull_reg && (!bfull_reg || shift_load)) begin
         buf_next = dreg_reg;
         bfull_next = 1'b1;
         dfull_next = 1'b0;
      end
      if (wr) begin
         unique case ({1'b0, avs_address[2:0]})
            `USTX_OFS_TXLOW: begin
               // Writes while the data register is full are dropped, protecting queued data
               if (dre || hpend_reg) begin
                  dreg_next[7:0] = avs_writedata[7:0];
                  if (size == USTX_SZ9L) begin
                     hpend_next = 1'b1;
                  end else begin
                     if (!is9h) dreg_next[8] = 1'b0;
                     hpend_next = 1'b0;
                     dfull_next = 1'b1;
                  end
                  txc_next = 1'b0;
               end
            end
            `USTX_OFS_TXHIGH: begin
               if (dre || hpend_reg) begin
                  dreg_next[8] = avs_writedata[0];
                  if (is9l) begin
                     hpend_next = 1'b0;
                     dfull_next = 1'b1;
                  end else begin
                     hpend_next = is9h;
                  end
               end
            end
            `USTX_OFS_STATUS: begin
               if (avs_writedata[`USTX_ST_TXC]) txc_next = 1'b0;
               if (avs_writedata[`USTX_ST_RXC]) rxc_next = 1'b0;
            end
            `USTX_OFS_CTRLA: ctrla_next = avs_writedata[7:0];
            `USTX_OFS_CTRLB: ctrlb_next = avs_writedata[7:0];
            `USTX_OFS_CTRLC: ctrlc_next = avs_writedata[7:0];
            `USTX_OFS_BAUD: baud_next = avs_writedata[15:0];
            default: ;
         endcase
      end
      // Hardware set wins over software clear
      if (frame_end && !dfull_next && !bfull_next && !shift_load && !hpend_next) begin
         txc_next = 1'b1;
      end
      if (rx_done) rxc_next = 1'b1;
      // Enable immediately, disable only once drained
      if (ctrlb_reg[`USTX_CB_TXEN]) begin
         txon_next = 1'b1;
      end else if (!dfull_reg && !bfull_reg && !shifter_busy && !hpend_reg) begin
         txon_next = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         baud_reg <= `USTX_BAUD_RST;
         ctrla_reg <= 8'h00;
         ctrlb_reg <= 8'h00;
         ctrlc_reg <= `USTX_CTRLC_RST;
         dreg_reg <= 9'h000;
         dfull_reg <= 1'b0;
         hpend_reg <= 1'b0;
         buf_reg <= 9'h000;
         bfull_reg <= 1'b0;
         txc_reg <= 1'b0;
         rxc_reg <= 1'b0;
         txon_reg <= 1'b0;
      end else begin
         baud_reg <= baud_next;
         ctrla_reg <= ctrla_next;
         ctrlb_reg <= ctrlb_next;
         ctrlc_reg <= ctrlc_next;
         dreg_reg <= dreg_next;
         dfull_reg <= dfull_next;
         hpend_reg <= hpend_next;
         buf_reg <= buf_next;
         bfull_reg <= bfull_next;
         txc_reg <= txc_next;
         rxc_reg <= rxc_next;
         txon_reg <= txon_next;
      end
   end
   // Read data is combinational so it stands at the sampling edge
   always_comb begin
      avs_readdata = 32'h0000_0000;
      if (rd) begin
         unique case ({1'b0, avs_address[2:0]})
            `USTX_OFS_STATUS: avs_readdata = {28'h000_0000, txon_reg, rxc_reg, dre, txc_reg};
            `USTX_OFS_CTRLA: avs_readdata = {24'h00_0000, ctrla_reg};
            `USTX_OFS_CTRLB: avs_readdata = {24'h00_0000, ctrlb_reg};
            `USTX_OFS_CTRLC: avs_readdata = {24'h00_0000, ctrlc_reg};
            `USTX_OFS_BAUD: avs_readdata = {16'h0000, baud_reg};
            default: avs_readdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fractional baud generator: one tick per sample period
   logic [9:0] pcnt_reg, pcnt_next;
   logic [5:0] facc_reg, facc_next;
   logic stretch_reg, stretch_next;
   logic [4:0] scnt_reg, scnt_next;
   logic sample_tick, bit_tick;
   logic [4:0] spb;
   always_comb begin
      if (sync_mode) spb = `USTX_S_SYNC;
      else if (ctrlb_reg[`USTX_CB_DSPEED]) spb = `USTX_S_DOUBLE;
      else spb = `USTX_S_NORMAL;
   end
   always_comb begin
      pcnt_next = pcnt_reg;
      facc_next = facc_reg;
      stretch_next = stretch_reg;
      sample_tick = 1'b0;
      if (!txon_reg) begin
         pcnt_next = 10'h001;
         facc_next = 6'h00;
         stretch_next = 1'b0;
      end else if (pcnt_reg >= baud_reg[15:6] && !stretch_reg) begin
         // Fraction only in async modes; sync uses the integer part alone
         if (!sync_mode && ({1'b0, facc_reg} + {1'b0, baud_reg[5:0]}) > 7'h3f) begin
            stretch_next = 1'b1;
         end else begin
            sample_tick = 1'b1;
            pcnt_next = 10'h001;
         end
         facc_next = sync_mode ? 6'h00 : facc_reg + baud_reg[5:0];
      end else if (stretch_reg) begin
         stretch_next = 1'b0;
         sample_tick = 1'b1;
         pcnt_next = 10'h001;
      end else begin
         pcnt_next = pcnt_reg + 10'h001;
      end
      scnt_next = scnt_reg;
      bit_tick = 1'b0;
      if (!txon_reg) begin
         scnt_next = 5'h00;
      end else if (sample_tick) begin
         if (scnt_reg + 5'h01 >= spb) begin
            scnt_next = 5'h00;
            bit_tick = ~(sync_mode & xclk_in);
         end else begin
            scnt_next = scnt_reg + 5'h01;
         end
      end
      if (sync_mode && xclk_in && txon_reg) bit_tick = xck_rise;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pcnt_reg <= 10'h001;
         facc_reg <= 6'h00;
         stretch_reg <= 1'b0;
         scnt_reg <= 5'h00;
      end else begin
         pcnt_reg <= pcnt_next;
         facc_reg <= facc_next;
         stretch_reg <= stretch_next;
         scnt_reg <= scnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame formatter
   ustx_state_t st_reg, st_next;
   logic [8:0] sh_reg, sh_next;
   logic [3:0] bcnt_reg, bcnt_next;
   logic par_reg, par_next;
   logic line_reg, line_next;
   logic [3:0] nbits;
   always_comb begin
      unique case (size)
         USTX_SZ5: nbits = 4'h5;
         USTX_SZ6: nbits = 4'h6;
         USTX_SZ7: nbits = 4'h7;
         USTX_SZ8: nbits = 4'h8;
         default: nbits = 4'h9;
      endcase
   end
   assign shifter_busy = (st_reg != USTX_IDLE);
   always_comb begin
      st_next = st_reg;
      sh_next = sh_reg;
      bcnt_next = bcnt_reg;
      par_next = par_reg;
      line_next = line_reg;
      shift_load = 1'b0;
      frame_end = 1'b0;
      if (bit_tick) begin
         unique case (st_reg)
            USTX_IDLE: begin
               line_next = 1'b1;
               if (bfull_reg) begin
                  shift_load = 1'b1;
                  sh_next = buf_reg & ((9'h001 << nbits) - 9'h001);
                  par_next = (par == USTX_PODD);
                  line_next = 1'b0;
                  st_next = USTX_START;
               end
            end
            USTX_START, USTX_DATA: begin
               line_next = sh_reg[0];
               par_next = par_reg ^ sh_reg[0];
               sh_next = {1'b0, sh_reg[8:1]};
               bcnt_next = (st_reg == USTX_START) ? 4'h1 : bcnt_reg + 4'h1;
               st_next = USTX_DATA;
               if (st_reg == USTX_DATA && bcnt_reg == nbits) begin
                  if (par != USTX_PNONE) begin
                     line_next = par_reg;
                     st_next = USTX_PARITY;
                  end else begin
                     line_next = 1'b1;
                     bcnt_next = 4'h0;
                     st_next = USTX_STOP;
                  end
               end
            end
            USTX_PARITY: begin
               line_next = 1'b1;
               bcnt_next = 4'h0;
               st_next = USTX_STOP;
            end
            USTX_STOP: begin
               if (ctrlc_reg[`USTX_CC_STOP2] && bcnt_reg == 4'h0) begin
                  bcnt_next = 4'h1;
               end else begin
                  frame_end = 1'b1;
                  // Next frame starts without idle gap
                  if (bfull_reg) begin
                     shift_load = 1'b1;
                     sh_next = buf_reg & ((9'h001 << nbits) - 9'h001);
                     par_next = (par == USTX_PODD);
                     line_next = 1'b0;
                     st_next = USTX_START;
                  end else begin
                     st_next = USTX_IDLE;
                  end
               end
            end
            default: st_next = USTX_IDLE;
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg <= USTX_IDLE;
         sh_reg <= 9'h000;
         bcnt_reg <= 4'h0;
         par_reg <= 1'b0;
         line_reg <= 1'b1;
      end else begin
         st_reg <= st_next;
         sh_reg <= sh_next;
         bcnt_reg <= bcnt_next;
         par_reg <= par_next;
         line_reg <= line_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin control
   always_comb begin
      txd_o = line_reg;
      txd_oe = txon_reg;
      if (ctrlb_reg[`USTX_CB_OPEN_DRAIN_ENABLE]) begin
         txd_o = 1'b0;
         txd_oe = txon_reg & ~line_reg;
      end
      line_driver_direction = shifter_busy;
      rx_line = ctrla_reg[`USTX_CA_LOOPBACK] ? line_reg : txi_sync_reg[1];
   end

   AST_START_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_reg == USTX_START) |-> !line_reg)
      else $error("start bit not low");
   AST_STOP_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_reg == USTX_STOP) |-> line_reg)
      else $error("stop bit not high");
   AST_IDLE_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_reg == USTX_IDLE && $past(st_reg) == USTX_IDLE) |-> line_reg)
      else $error("idle line not high");
   AST_TXC_SET: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(txc_reg) |-> !dfull_reg && !bfull_reg)
      else $error("complete flag with data pending");
   AST_DIS_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(txon_reg) |-> !$past(shifter_busy) && !$past(bfull_reg))
      else $error("disable before drain");
   AST_PIN_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
      !txon_reg |-> !txd_oe)
      else $error("pin driven while disabled");
   AST_LOAD_ORDER: assert property (@(posedge mclk) disable iff (!rst_n)
      shift_load |-> bfull_reg)
      else $error("shifter loaded from empty buffer");
   AST_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
      !line_reg |-> line_driver_direction)
      else $error("direction low during frame");
endmodule : ustx_top

// ===== verilog/ustx_consts.svh
// Register offsets, field positions, reset values and timing counts for the serial transmitter
`ifndef USTX_CONSTS_SVH
`define USTX_CONSTS_SVH
// Word offsets (one 32-bit register per address)
`define USTX_OFS_TXLOW 4'h0
`define USTX_OFS_TXHIGH 4'h1
`define USTX_OFS_STATUS 4'h2
`define USTX_OFS_CTRLA 4'h3
`define USTX_OFS_CTRLB 4'h4
`define USTX_OFS_CTRLC 4'h5
`define USTX_OFS_BAUD 4'h6
// Status bits
`define USTX_ST_TXC 0
`define USTX_ST_DRE 1
`define USTX_ST_RXC 2
`define USTX_ST_TXON 3
// Control A bits
`define USTX_CA_LOOPBACK 0
// Control B bits
`define USTX_CB_TXEN 0
`define USTX_CB_OPEN_DRAIN_ENABLE 1
`define USTX_CB_DSPEED 2
// Control C fields
`define USTX_CC_SIZE_LSB 0
`define USTX_CC_PAR_LSB 3
`define USTX_CC_STOP2 5
`define USTX_CC_SYNC 6
`define USTX_CC_XCLKIN 7
// Reset values
`define USTX_BAUD_RST 16'h0040
`define USTX_CTRLC_RST 8'h03
// Samples per bit
`define USTX_S_NORMAL 5'h10
`define USTX_S_DOUBLE 5'h08
`define USTX_S_SYNC 5'h02
`endif

// ===== verilog/ustx_pkg.sv
// Types for the serial transmitter
package ustx_pkg;
   typedef enum logic [2:0] {
      USTX_SZ5 = 3'h0,
      USTX_SZ6 = 3'h1,
      USTX_SZ7 = 3'h2,
      USTX_SZ8 = 3'h3,
      USTX_SZ9L = 3'h6,
      USTX_SZ9H = 3'h7
   } ustx_size_t;
   typedef enum logic [1:0] {
      USTX_PNONE = 2'h0,
      USTX_PEVEN = 2'h2,
      USTX_PODD = 2'h3
   } ustx_par_t;
   typedef enum {USTX_IDLE, USTX_START, USTX_DATA, USTX_PARITY, USTX_STOP} ustx_state_t;
endpackage : ustx_pkg

// ===== bench/ustx_line_model.sv
// Remote serial receiver model that decodes frames seen on the line
`timescale 1ns/1ps
module ustx_line_model (
   // Clock and line
   input wire logic mclk,
   input wire logic line,
   // Expected format
   input wire logic [15:0] bit_clks,
   input wire logic [3:0] nbits,
   input wire logic [1:0] par,
   input wire logic stop2,
   // Decoded results
   output logic rx_done,
   output logic frame_valid,
   output logic [8:0] frame_data,
   output logic frame_err,
   output int start_gap
);
   int cnt;
   int last;
   logic p;
   ////////////////////////////////////////////////////////////////////////////////
   // Every wait is counted so that start spacing is exact in clocks
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk);
         cnt++;
      end
   endtask : tick
   initial begin
      {rx_done, frame_valid, frame_data, frame_err, p} = '0;
      cnt = 0;
      last = 0;
      start_gap = 0;
      forever begin
         while (line !== 1'b0) tick(1);
         start_gap = cnt - last;
         last = cnt;
         tick(bit_clks / 2);
         frame_err = (line !== 1'b0);
         p = 1'b0;
         frame_data = '0;
         for (int i = 0; i < nbits; i++) begin
            tick(bit_clks);
            frame_data[i] = line;
            p ^= line;
         end
         if (par != 2'h0) begin
            tick(bit_clks);
            if ((p ^ line) !== par[0]) frame_err = 1'b1;
         end
         tick(bit_clks);
         if (line !== 1'b1) frame_err = 1'b1;
         rx_done <= 1'b1;
         tick(1);
         rx_done <= 1'b0;
         if (stop2) begin
            tick(bit_clks - 1);
            if (line !== 1'b1) frame_err = 1'b1;
         end
         frame_valid <= 1'b1;
         tick(1);
         frame_valid <= 1'b0;
      end
   end
endmodule : ustx_line_model

// ===== bench/tb.sv
// Self-checking bench for the serial transmitter with a remote receiver model
`timescale 1ns/1ps
`include "ustx_consts.svh"
module tb;
   logic mclk;
   logic rst_n;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic txd_o;
   logic txd_oe;
   logic pin;
   logic rx_line;
   logic line_driver_direction;
   logic rx_done;
   logic frame_valid;
   logic frame_err;
   logic [8:0] frame_data;
   int start_gap;
   logic [15:0] bit_clks;
   logic [3:0] nbits;
   logic [1:0] par;
   logic stop2;
   logic [2:0] size_code;
   int mismatches;
   int total_checks;
   int cyc = 0;
   int gap_exp;
   int gap_skip;
   int n;
   logic [31:0] q;
   logic [8:0] exp_q[$];
   logic [2:0] szt[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
   // Host-side transfer clock, run only while external-clock frames are sent
   logic transfer_clock_pin = 1'b0;
   logic xck_run = 1'b0;
   int xck_cnt = 0;
   // Pulled-up pin: released or driven
   assign pin = txd_oe ? txd_o : 1'b1;
   ustx_top #(.ADDR_W(4)) ustx_top_inst (.mclk(mclk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .txd_o(txd_o), .txd_oe(txd_oe), .txd_i(pin),
      .xck_i(transfer_clock_pin), .line_driver_direction(line_driver_direction), .rx_line(rx_line),
      .rx_done(rx_done));
   ustx_line_model ustx_line_model_inst (.mclk(mclk), .line(pin), .bit_clks(bit_clks),
      .nbits(nbits), .par(par), .stop2(stop2), .rx_done(rx_done),
      .frame_valid(frame_valid), .frame_data(frame_data), .frame_err(frame_err),
      .start_gap(start_gap));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One bus transfer; the edge after release is left free
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
         @(posedge mclk);
         k++;
      end
      if (k >= 50) chk("wait state limit", 0, 1);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic wait_stat(input int b);
      int k;
      k = 0;
      do begin
         bus(1'b0, `USTX_OFS_STATUS, 32'h0000_0000);
         k++;
      end while (q[b] !== 1'b1 && k < 3000);
      chk("status wait", 1, q[b]);
   endtask : wait_stat
   task automatic send(input logic [8:0] d);
      wait_stat(`USTX_ST_DRE);
      if (size_code == 3'h7) bus(1'b1, `USTX_OFS_TXHIGH, {31'h0, d[8]});
      bus(1'b1, `USTX_OFS_TXLOW, {24'h00_0000, d[7:0]});
      if (size_code == 3'h6) bus(1'b1, `USTX_OFS_TXHIGH, {31'h0, d[8]});
      exp_q.push_back(d & 9'((1 << nbits) - 1));
   endtask : send
   task automatic cfg(input logic [2:0] sz, input logic [1:0] pr, input logic s2);
      size_code = sz;
      nbits = (sz > 3'h3) ? 4'h9 : {1'b0, sz} + 4'h5;
      par = pr;
      stop2 = s2;
      bus(1'b1, `USTX_OFS_CTRLC, {26'h0, s2, pr, sz});
   endtask : cfg
   task automatic drain();
      wait_stat(`USTX_ST_TXC);
      chk("frames pending at complete", 0, exp_q.size());
      bus(1'b1, `USTX_OFS_STATUS, 32'h0000_0001);
      bus(1'b0, `USTX_OFS_STATUS, 32'h0000_0000);
      chk("complete cleared", 0, q[`USTX_ST_TXC]);
      chk("direction idle", 0, line_driver_direction);
   endtask : drain
   // Three frames queued at once must leave no idle gap
   task automatic burst(input int bc);
      bit_clks = 16'(bc);
      gap_exp = bc * 10;
      gap_skip = 1;
      repeat (3) send(9'($urandom));
      drain();
      gap_exp = 0;
   endtask : burst
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         stop_test();
      end
   end
   // Rising edge every 20 clocks while running
   always @(posedge mclk) begin
      if (xck_run) begin
         xck_cnt <= (xck_cnt == 9) ? 0 : xck_cnt + 1;
         if (xck_cnt == 9) transfer_clock_pin <= ~transfer_clock_pin;
      end
   end
   always @(posedge mclk) begin
      if (frame_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unexpected frame", 0, 1);
         end else begin
            chk("frame data", exp_q.pop_front(), frame_data);
            chk("frame error", 0, frame_err);
            if (gap_skip > 0) gap_skip--;
            else if (gap_exp > 0) chk("start spacing", gap_exp, start_gap);
         end
      end
   end
   initial begin
      {rst_n, avs_address, avs_read, avs_write, avs_writedata} = '0;
      {mismatches, total_checks, gap_exp, gap_skip} = '0;
      bit_clks = 16'h0020;
      void'($urandom(96429));
      cfg_defaults: begin
         nbits = 4'h8;
         par = 2'h0;
         stop2 = 1'b0;
         size_code = 3'h3;
      end
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk("idle line", 1, txd_o);
      chk("pin released", 0, txd_oe);
      bus(1'b0, `USTX_OFS_BAUD, 32'h0000_0000);
      chk("divider reset", `USTX_BAUD_RST, q);
      bus(1'b0, `USTX_OFS_CTRLC, 32'h0000_0000);
      chk("format reset", `USTX_CTRLC_RST, q);
      bus(1'b0, 4'h7, 32'h0000_0000);
      chk("unmapped read", 0, q);
      $display("test reset done");
      bus(1'b1, `USTX_OFS_BAUD, 32'h0000_0080);
      cfg(3'h3, 2'h0, 1'b0);
      bus(1'b1, `USTX_OFS_CTRLB, 32'h0000_0001);
      foreach (szt[i]) begin
         for (int pr = 0; pr < 4; pr++) begin
            for (int s = 0; s < 2; s++) begin
               if (pr != 1) begin
                  cfg(szt[i], 2'(pr), 1'(s));
                  send(9'($urandom));
                  drain();
               end
            end
         end
      end
      $display("test formats done");
      cfg(3'h3, 2'h0, 1'b0);
      gap_exp = 320;
      gap_skip = 1;
      n = 0;
      repeat (2) begin
         bus(1'b0, `USTX_OFS_STATUS, 32'h0000_0000);
         while (q[`USTX_ST_DRE] === 1'b1 && n < 6) begin
            send(9'($urandom));
            n++;
            bus(1'b0, `USTX_OFS_STATUS, 32'h0000_0000);
         end
         // Once the shifter holds a frame, nothing frees a store until its end
         repeat (40) @(posedge mclk);
      end
      chk("write buffer depth", 3, n);
      chk("complete while busy", 0, q[`USTX_ST_TXC]);
      bus(1'b1, `USTX_OFS_TXLOW, 32'h0000_00A5);
      repeat (40) @(posedge mclk);
      chk("direction busy", 1, line_driver_direction);
      drain();
      gap_exp = 0;
      $display("test buffer done");
      bus(1'b1, `USTX_OFS_CTRLB, 32'h0000_0005);
      burst(16);
      bus(1'b1, `USTX_OFS_CTRLB, 32'h0000_0001);
      bus(1'b1, `USTX_OFS_BAUD, 32'h0000_00A0);
      burst(40);
      $display("test rates done");
      send(9'($urandom));
      send(9'($urandom));
      bus(1'b1, `USTX_OFS_CTRLB, 32'h0000_0000);
      chk("pin held while draining", 1, txd_oe);
      drain();
      repeat (4) @(posedge mclk);
      chk("pin released after drain", 0, txd_oe);
      $display("test disable done");
      bus(1'b1, `USTX_OFS_STATUS, 32'h0000_0004);
      bus(1'b1, `USTX_OFS_CTRLA, 32'h0000_0001);
      bus(1'b1, `USTX_OFS_CTRLB, 32'h0000_0003);
      send(9'($urandom));
      n = 0;
      while (pin !== 1'b0 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      // Looked at before the pin synchroniser could deliver the same low
      chk("loopback line", 0, rx_line);
      repeat (4) @(posedge mclk);
      chk("open drain output", 1, txd_oe);
      drain();
      bus(1'b0, `USTX_OFS_STATUS, 32'h0000_0000);
      chk("receive flag", 1, q[`USTX_ST_RXC]);
      bus(1'b1, `USTX_OFS_STATUS, 32'h0000_0004);
      bus(1'b0, `USTX_OFS_STATUS, 32'h0000_0000);
      chk("receive flag cleared", 0, q[`USTX_ST_RXC]);
      $display("test loopback done");
      bus(1'b1, `USTX_OFS_CTRLA, 32'h0000_0000);
      bus(1'b1, `USTX_OFS_CTRLB, 32'h0000_0001);
      bus(1'b1, `USTX_OFS_BAUD, 32'h0000_0100);
      bus(1'b1, `USTX_OFS_CTRLC, 32'h0000_0043);
      burst(8);
      bus(1'b1, `USTX_OFS_CTRLC, 32'h0000_00C3);
      xck_run <= 1'b1;
      burst(20);
      xck_run <= 1'b0;
      $display("test sync done");
      stop_test();
   end
endmodule : tb
